// >>> design/piopb_regs.vh
// Register indices, field positions and reset values of the I/O port bank.
// Assumes the includer turns an index into a byte address by times four.
`ifndef PIOPB_REGS_VH
`define PIOPB_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define PIOPB_IDX_PORT14_CTRL 10'h3DE
`define PIOPB_IDX_P0_DATA 10'h3E0
`define PIOPB_IDX_P1_DATA 10'h3E1
`define PIOPB_IDX_P0_DIR 10'h3E2
`define PIOPB_IDX_P1_DIR 10'h3E3
`define PIOPB_IDX_P2_DATA 10'h3E4
`define PIOPB_IDX_P3_DATA 10'h3E5
`define PIOPB_IDX_P2_DIR 10'h3E6
`define PIOPB_IDX_P3_DIR 10'h3E7
`define PIOPB_IDX_P4_DATA 10'h3E8
`define PIOPB_IDX_P5_DATA 10'h3E9
`define PIOPB_IDX_P4_DIR 10'h3EA
`define PIOPB_IDX_P5_DIR 10'h3EB
`define PIOPB_IDX_P6_DATA 10'h3EC
`define PIOPB_IDX_P7_DATA 10'h3ED
`define PIOPB_IDX_P6_DIR 10'h3EE
`define PIOPB_IDX_P7_DIR 10'h3EF
`define PIOPB_IDX_P8_DATA 10'h3F0
`define PIOPB_IDX_P9_DATA 10'h3F1
`define PIOPB_IDX_P8_DIR 10'h3F2
`define PIOPB_IDX_P9_DIR 10'h3F3
`define PIOPB_IDX_P10_DATA 10'h3F4
`define PIOPB_IDX_P11_DATA 10'h3F5
`define PIOPB_IDX_P10_DIR 10'h3F6
`define PIOPB_IDX_P11_DIR 10'h3F7
`define PIOPB_IDX_P12_DATA 10'h3F8
`define PIOPB_IDX_P13_DATA 10'h3F9
`define PIOPB_IDX_P12_DIR 10'h3FA
`define PIOPB_IDX_P13_DIR 10'h3FB
`define PIOPB_IDX_PULLUP0 10'h3FC
`define PIOPB_IDX_PULLUP1 10'h3FD
`define PIOPB_IDX_PULLUP2 10'h3FE
`define PIOPB_IDX_PULLUP3 10'h3DF
`define PIOPB_IDX_READBACK 10'h3FF

// ----------------------------------------------------------------
// Decode kinds
// ----------------------------------------------------------------
`define PIOPB_KIND_DATA 2'h0
`define PIOPB_KIND_DIR 2'h1
`define PIOPB_KIND_PULL 2'h2
`define PIOPB_KIND_RDBK 2'h3

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PIOPB_RDBK_SEL_BIT 0
`define PIOPB_UPPER_EN_BIT 7
`define PIOPB_P14_GROUP_BIT 6
`define PIOPB_P14_DIR_LSB 4
`define PIOPB_NMI_PORT 8
`define PIOPB_NMI_BIT 5
`define PIOPB_OD_PORT_A 7
`define PIOPB_OD_PORT_B 9
`define PIOPB_OD_BIT 1
`define PIOPB_PULL2_MASK 8'h3F
`define PIOPB_PULL3_MASK 8'hFF
`define PIOPB_PULL_RESET 8'h00
`define PIOPB_DIR_RESET 8'h00
`define PIOPB_DATA_RESET 8'h00
`define PIOPB_RESP_OKAY 2'h0
`define PIOPB_RESP_DECERR 2'h3

`endif

// >>> design/piopb_sync.v
// Two-stage level synchroniser, one chain per bit.
// Assumes each input bit is a slow level sampled on aclk.
`timescale 1ns/1ps

module piopb_sync #(
    parameter WIDTH = 8
) (
    input wire aclk, // System clock
    input wire aresetn, // Synchronous reset, active low
    input wire [WIDTH-1:0] din, // Asynchronous levels
    output wire [WIDTH-1:0] dout // Synchronised levels
);

reg [WIDTH-1:0] stage1_ff;
reg [WIDTH-1:0] stage2_ff;

// First stage feeds only the second stage
always @(posedge aclk) begin
    if (!aresetn) begin
        stage1_ff <= {WIDTH{1'b0}};
        stage2_ff <= {WIDTH{1'b0}};
    end else begin
        stage1_ff <= din;
        stage2_ff <= stage1_ff;
    end
end

assign dout = stage2_ff;

endmodule

// >>> design/piopb_top.v
// Programmable I/O port bank: ports 0..14 behind an AXI4-Lite slave.
// Assumes pins and peripheral signals are levels; pad wires resolved outside.
// Functional notes
// - Each port line except port 8 line 5 can be set input or output by its own bit.
// - Direction register bits map one to one onto port lines.
// - Pull-ups selected per group of four consecutive lines, one bit each; port 11 group bits are write-masked to 0.
// - Pull-up connects only with group bit set and line in input mode.
// - Port 8 line 5 is input-only, no pull-up, reads interrupt pin level.
// - Interrupt-shared line has no direction bit; its data bit is read-only.
// - Peripheral output other than serial four or D/A forces pin output.
// - Input line: read gives pin level; write only updates output latch.
// - Output line: read gives latch; latch drives pin, 0 low 1 high.
// - Readback select set: port 1 reads return latch whatever direction.
// - Upper-port enable clear forces data registers of ports 11..14 to 00h.
// - Port 7 line 1 and port 9 line 1 are open-drain, high floats.
// - Port 14 control: data in bits 0,1; direction in bits 4,5.
// - Port 14 control bits 3:2 and 7:6 ignore writes, read undefined.
// - Pull-up register 0: bit 0 is port 0 lines 0..3; resets 00h.
// - 87 lines on ports 0..10 small package, 113 on 0..14 large.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "piopb_regs.vh"

module piopb_top #(
    parameter LARGE_PKG = 1, // 1: ports 0..14, 0: ports 0..10
    parameter ADDR_W = 12 // AXI address width
) (
    input wire aclk, // System clock
    input wire aresetn, // Synchronous reset, active low
    input wire [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire [2:0] s_axi_awprot, // Write protection, unused
    input wire s_axi_awvalid, // Write address valid
    output wire s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write byte strobes
    input wire s_axi_wvalid, // Write data valid
    output wire s_axi_wready, // Write data ready
    output wire [1:0] s_axi_bresp, // Write response
    output wire s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire [2:0] s_axi_arprot, // Read protection, unused
    input wire s_axi_arvalid, // Read address valid
    output wire s_axi_arready, // Read address ready
    output wire [31:0] s_axi_rdata, // Read data
    output wire [1:0] s_axi_rresp, // Read response
    output wire s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire [119:0] pin_in, // Pad levels, port p line b at p*8+b
    input wire [119:0] periph_oe, // Peripheral owns pin as output
    input wire [119:0] periph_out, // Peripheral output level
    output wire [119:0] pin_out, // Pad output level
    output wire [119:0] pin_oe, // Pad output enable, high drives
    output wire [119:0] pin_pu // Pull-up resistor connect
);

// ----------------------------------------------------------------
// Address decode
// ----------------------------------------------------------------
// Returns {hit, kind[1:0], port[3:0]}
function [6:0] dec;
    input [9:0] idx;
    begin
        case (idx)
            `PIOPB_IDX_P0_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'h0};
            `PIOPB_IDX_P1_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'h1};
            `PIOPB_IDX_P2_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'h2};
            `PIOPB_IDX_P3_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'h3};
            `PIOPB_IDX_P4_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'h4};
            `PIOPB_IDX_P5_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'h5};
            `PIOPB_IDX_P6_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'h6};
            `PIOPB_IDX_P7_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'h7};
            `PIOPB_IDX_P8_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'h8};
            `PIOPB_IDX_P9_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'h9};
            `PIOPB_IDX_P10_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'hA};
            `PIOPB_IDX_P11_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'hB};
            `PIOPB_IDX_P12_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'hC};
            `PIOPB_IDX_P13_DATA: dec = {1'b1, `PIOPB_KIND_DATA, 4'hD};
            `PIOPB_IDX_PORT14_CTRL: dec = {1'b1, `PIOPB_KIND_DATA, 4'hE};
            `PIOPB_IDX_P0_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'h0};
            `PIOPB_IDX_P1_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'h1};
            `PIOPB_IDX_P2_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'h2};
            `PIOPB_IDX_P3_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'h3};
            `PIOPB_IDX_P4_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'h4};
            `PIOPB_IDX_P5_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'h5};
            `PIOPB_IDX_P6_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'h6};
            `PIOPB_IDX_P7_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'h7};
            `PIOPB_IDX_P8_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'h8};
            `PIOPB_IDX_P9_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'h9};
            `PIOPB_IDX_P10_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'hA};
            `PIOPB_IDX_P11_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'hB};
            `PIOPB_IDX_P12_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'hC};
            `PIOPB_IDX_P13_DIR: dec = {1'b1, `PIOPB_KIND_DIR, 4'hD};
            `PIOPB_IDX_PULLUP0: dec = {1'b1, `PIOPB_KIND_PULL, 4'h0};
            `PIOPB_IDX_PULLUP1: dec = {1'b1, `PIOPB_KIND_PULL, 4'h1};
            `PIOPB_IDX_PULLUP2: dec = {1'b1, `PIOPB_KIND_PULL, 4'h2};
            `PIOPB_IDX_PULLUP3: dec = {1'b1, `PIOPB_KIND_PULL, 4'h3};
            `PIOPB_IDX_READBACK: dec = {1'b1, `PIOPB_KIND_RDBK, 4'h0};
            default: dec = 7'h00;
        endcase
    end
endfunction

// Ports 11..14 and their registers vanish in the small package
function port_present;
    input [3:0] p;
    begin
        port_present = (p <= 4'hA) || (LARGE_PKG != 0);
    end
endfunction

// Line exists: port 14 has only lines 0 and 1
function line_exists;
    input integer p;
    input integer b;
    begin
        line_exists = (p < 14) || (b < 2);
    end
endfunction

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
reg [7:0] data_ff [0:14]; // Output latches
reg [7:0] dir_ff [0:14]; // 1 = output
reg [7:0] pull_ff [0:3]; // Pull-up group enables
reg rdbk_sel_ff;
reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
reg aw_got_ff, w_got_ff, rd_pend_ff;
reg [1:0] bresp_ff, rresp_ff;
reg [9:0] wr_idx_ff, rd_idx_ff;
reg [7:0] wdata_ff;
reg wstrb_ff;
reg [31:0] rdata_ff;
reg [119:0] pin_out_ff, pin_oe_ff, pin_pu_ff;
reg [119:0] nxt_pin_out, nxt_pin_oe, nxt_pin_pu;
reg [7:0] rd_byte;
wire [119:0] pin_sync;
wire upper_en = pull_ff[3][`PIOPB_UPPER_EN_BIT];
wire [6:0] wr_dec = dec(wr_idx_ff);
wire [6:0] rd_dec = dec(rd_idx_ff);
wire [3:0] wr_port = wr_dec[3:0];
wire [3:0] rd_port = rd_dec[3:0];
wire wr_hit = wr_dec[6] && port_present(wr_port);
wire rd_hit = rd_dec[6] && port_present(rd_port);
integer i, b, g;

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
piopb_sync #(
    .WIDTH(120)
) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(pin_in),
    .dout(pin_sync)
);

// ----------------------------------------------------------------
// Pad drive, enable and pull-up
// ----------------------------------------------------------------
always @* begin
    nxt_pin_out = 120'h0;
    nxt_pin_oe = 120'h0;
    nxt_pin_pu = 120'h0;
    for (i = 0; i < 15; i = i + 1) begin
        for (b = 0; b < 8; b = b + 1) begin
            g = (i == 14) ? (24 + `PIOPB_P14_GROUP_BIT) : (i * 2 + b / 4);
            if (line_exists(i, b) && port_present(i[3:0]) &&
                    (i < 11 || upper_en)) begin
                if (i == `PIOPB_NMI_PORT && b == `PIOPB_NMI_BIT) begin
                    nxt_pin_oe[i*8+b] = 1'b0;
                end else if ((i == `PIOPB_OD_PORT_A ||
                        i == `PIOPB_OD_PORT_B) && b == `PIOPB_OD_BIT) begin
                    // Only ever pulls low; a high leaves the pad floating
                    nxt_pin_out[i*8+b] = 1'b0;
                    nxt_pin_oe[i*8+b] = periph_oe[i*8+b] ?
                        ~periph_out[i*8+b] :
                        (dir_ff[i][b] & ~data_ff[i][b]);
                end else begin
                    nxt_pin_out[i*8+b] = periph_oe[i*8+b] ?
                        periph_out[i*8+b] : data_ff[i][b];
                    nxt_pin_oe[i*8+b] = periph_oe[i*8+b] |
                        dir_ff[i][b];
                    nxt_pin_pu[i*8+b] = pull_ff[g/8][g%8] &
                        ~dir_ff[i][b] & ~periph_oe[i*8+b];
                end
            end
        end
    end
end

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
always @* begin
    rd_byte = 8'h00;
    if (rd_hit) begin
        case (rd_dec[5:4])
            `PIOPB_KIND_DATA: begin
                for (b = 0; b < 8; b = b + 1) begin
                    if (!line_exists(rd_port, b)) begin
                        rd_byte[b] = 1'b0;
                    end else if (rd_port == `PIOPB_NMI_PORT &&
                            b == `PIOPB_NMI_BIT) begin
                        rd_byte[b] = pin_sync[rd_port*8+b];
                    end else if (dir_ff[rd_port][b] || (rd_port == 4'h1 &&
                            rdbk_sel_ff)) begin
                        rd_byte[b] = data_ff[rd_port][b];
                    end else begin
                        rd_byte[b] = pin_sync[rd_port*8+b];
                    end
                end
                if (rd_port == 4'hE) begin
                    rd_byte[`PIOPB_P14_DIR_LSB+1:`PIOPB_P14_DIR_LSB] =
                        dir_ff[14][1:0];
                end
                if (rd_port >= 4'hB && !upper_en) begin
                    rd_byte = 8'h00;
                end
            end
            `PIOPB_KIND_DIR: rd_byte = dir_ff[rd_port];
            `PIOPB_KIND_PULL: rd_byte = pull_ff[rd_port[1:0]];
            `PIOPB_KIND_RDBK: rd_byte = {7'h00, rdbk_sel_ff};
            default: rd_byte = 8'h00;
        endcase
    end
end

// ----------------------------------------------------------------
// AXI4-Lite write path and register updates
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
        bvalid_ff <= 1'b0;
        bresp_ff <= `PIOPB_RESP_OKAY;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        wr_idx_ff <= 10'h000;
        wdata_ff <= 8'h00;
        wstrb_ff <= 1'b0;
        rdbk_sel_ff <= 1'b0;
        for (i = 0; i < 15; i = i + 1) begin
            data_ff[i] <= `PIOPB_DATA_RESET;
            dir_ff[i] <= `PIOPB_DIR_RESET;
        end
        for (i = 0; i < 4; i = i + 1) begin
            pull_ff[i] <= `PIOPB_PULL_RESET;
        end
    end else begin
        if (s_axi_awvalid && awready_ff) begin
            wr_idx_ff <= s_axi_awaddr[11:2];
            aw_got_ff <= 1'b1;
            awready_ff <= 1'b0;
        end
        if (s_axi_wvalid && wready_ff) begin
            wdata_ff <= s_axi_wdata[7:0];
            wstrb_ff <= s_axi_wstrb[0];
            w_got_ff <= 1'b1;
            wready_ff <= 1'b0;
        end
        if (aw_got_ff && w_got_ff && !bvalid_ff) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? `PIOPB_RESP_OKAY : `PIOPB_RESP_DECERR;
            // Only the low byte lane carries register bits
            if (wr_hit && wstrb_ff) begin
                case (wr_dec[5:4])
                    `PIOPB_KIND_DATA: begin
                        if (wr_port == 4'hE) begin
                            data_ff[14] <= {6'h00, wdata_ff[1:0]};
                            dir_ff[14] <= {6'h00,
                                wdata_ff[`PIOPB_P14_DIR_LSB+1:
                                `PIOPB_P14_DIR_LSB]};
                        end else begin
                            data_ff[wr_port] <= wdata_ff;
                        end
                    end
                    `PIOPB_KIND_DIR: begin
                        dir_ff[wr_port] <= wdata_ff;
                        if (wr_port == `PIOPB_NMI_PORT) begin
                            dir_ff[wr_port][`PIOPB_NMI_BIT] <= 1'b0;
                        end
                    end
                    `PIOPB_KIND_PULL: begin
                        if (wr_port == 4'h2) begin
                            pull_ff[2] <= wdata_ff & `PIOPB_PULL2_MASK;
                        end else if (wr_port == 4'h3) begin
                            pull_ff[3] <= wdata_ff & `PIOPB_PULL3_MASK;
                        end else begin
                            pull_ff[wr_port[1:0]] <= wdata_ff;
                        end
                    end
                    `PIOPB_KIND_RDBK: begin
                        rdbk_sel_ff <= wdata_ff[`PIOPB_RDBK_SEL_BIT];
                    end
                    default: rdbk_sel_ff <= rdbk_sel_ff;
                endcase
            end
        end
        if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
        end
        // Disabled upper ports hold cleared latches; overrides any write
        if (!upper_en) begin
            for (i = 11; i < 15; i = i + 1) begin
                data_ff[i] <= 8'h00;
            end
        end
    end
end

// ----------------------------------------------------------------
// AXI4-Lite read path and pad registers
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        arready_ff <= 1'b1;
        rvalid_ff <= 1'b0;
        rd_pend_ff <= 1'b0;
        rd_idx_ff <= 10'h000;
        rdata_ff <= 32'h00000000;
        rresp_ff <= `PIOPB_RESP_OKAY;
        pin_out_ff <= 120'h0;
        pin_oe_ff <= 120'h0;
        pin_pu_ff <= 120'h0;
    end else begin
        pin_out_ff <= nxt_pin_out;
        pin_oe_ff <= nxt_pin_oe;
        pin_pu_ff <= nxt_pin_pu;
        if (s_axi_arvalid && arready_ff) begin
            rd_idx_ff <= s_axi_araddr[11:2];
            arready_ff <= 1'b0;
            rd_pend_ff <= 1'b1;
        end
        if (rd_pend_ff) begin
            rd_pend_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h000000, rd_byte};
            rresp_ff <= rd_hit ? `PIOPB_RESP_OKAY : `PIOPB_RESP_DECERR;
        end
        if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end
end

assign s_axi_awready = awready_ff;
assign s_axi_wready = wready_ff;
assign s_axi_bvalid = bvalid_ff;
assign s_axi_bresp = bresp_ff;
assign s_axi_arready = arready_ff;
assign s_axi_rvalid = rvalid_ff;
assign s_axi_rdata = rdata_ff;
assign s_axi_rresp = rresp_ff;
assign pin_out = pin_out_ff;
assign pin_oe = pin_oe_ff;
assign pin_pu = pin_pu_ff;

endmodule

// >>> verif/piopb_properties.sv
// Checker: bus timing and pad assertions.
// Assumes a bind to piopb_top; sees its ports only.
`timescale 1ns/1ps

module piopb_props (
    input wire aclk, // Clock
    input wire aresetn, // Sync reset, active low
    input wire s_axi_awvalid, // AW valid
    input wire s_axi_awready, // AW ready
    input wire s_axi_wvalid, // W valid
    input wire s_axi_wready, // W ready
    input wire s_axi_bvalid, // B valid
    input wire s_axi_bready, // B ready
    input wire s_axi_arvalid, // AR valid
    input wire s_axi_arready, // AR ready
    input wire s_axi_rvalid, // R valid
    input wire s_axi_rready, // R ready
    input wire [31:0] s_axi_rdata, // Read data
    input wire [119:0] periph_oe, // Peripheral owns pin
    input wire [119:0] periph_out, // Peripheral level
    input wire [119:0] pin_out, // Pad level
    input wire [119:0] pin_oe, // Pad drive
    input wire [119:0] pin_pu // Pad pull-up
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer late");
    chk_write_busy: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write not blocked");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("bvalid held");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        !s_axi_rvalid ##1 s_axi_rvalid) else $error("read answer late");
    chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready) else $error("read not released");
    chk_rdata_upper: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h0) else $error("rdata upper set");
    chk_nmi_undriven: assert property (
        !pin_oe[69] && !pin_pu[69]) else $error("shared line driven");
    chk_od_no_high: assert property (
        !pin_out[57] && !pin_out[73]) else $error("open-drain driven high");
    chk_pu_input_only: assert property (
        (pin_pu & pin_oe) == 120'h0) else $error("pull-up on driven line");
    chk_periph_force: assert property ($past(periph_oe[8]) |->
        pin_oe[8] && pin_out[8] == $past(periph_out[8]))
        else $error("peripheral not forced");
    chk_p14_unused: assert property (
        pin_oe[119:114] == 6'h0 && pin_pu[119:114] == 6'h0)
        else $error("absent lines active");
endmodule

// >>> verif/piopb_pins.sv
// Pin model: resolves each pad from drive, pull-up and outside level.
// Assumes the bench varies ext_lvl so undriven pads never look stable.
`timescale 1ns/1ps

module piopb_pins (
    input wire [119:0] pin_out, // Pad level
    input wire [119:0] pin_oe, // Pad drive
    input wire [119:0] pin_pu, // Pull-up connected
    input wire [119:0] ext_lvl, // Outside level when released
    output wire [119:0] pin_in // Resolved pad level
);
    // Released pads show high when pulled up, else the outside level
    assign pin_in = (pin_oe & pin_out)
        | (~pin_oe & pin_pu)
        | (~pin_oe & ~pin_pu & ext_lvl);
endmodule

// >>> verif/piopb_tb.sv
// Testbench: AXI4-Lite stimulus, read and pad checks.
// Assumes piopb_pins and piopb_props are compiled alongside.
`timescale 1ns/1ps
`include "piopb_regs.vh"

module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready;
    logic s_axi_arvalid = 1'b0, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [119:0] pin_in, pin_out, pin_oe, pin_pu;
    logic [119:0] periph_oe = 120'h0, periph_out = 120'h0, ext_lvl = 120'h0;
    logic [7:0] d, l, e;
    int mismatches = 0, checks_done = 0, cycles = 0, p;
    // Data indices of ports 0..11; direction is two above
    logic [9:0] didx [12] = '{10'h3E0, 10'h3E1, 10'h3E4, 10'h3E5,
        10'h3E8, 10'h3E9, 10'h3EC, 10'h3ED, 10'h3F0, 10'h3F1, 10'h3F4,
        10'h3F5};

    piopb_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pin_in, .periph_oe, .periph_out, .pin_out, .pin_oe,
        .pin_pu);
    piopb_pins pins (.pin_out, .pin_oe, .pin_pu, .ext_lvl, .pin_in);

    always #50 aclk = ~aclk;

    // ------------------------------------------------------------
    // Bus tasks and checking
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] idx, output logic [31:0] v,
        output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Two sync flops plus pad register
    task automatic settle;
        repeat (4) @(posedge aclk);
    endtask

    function automatic logic [7:0] exp_rd(input logic [7:0] dir, lat, pin);
        return (dir & lat) | (~dir & pin);
    endfunction

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        d = $urandom(32'h06DC);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`PIOPB_IDX_PULLUP0, rv, resp);
        check("pullup0 reset", rv, 32'h0);
        for (int k = 0; k < 14; k++) begin
            p = k % 7;
            d = $urandom;
            l = $urandom;
            e = $urandom;
            ext_lvl[p*8 +: 8] <= e;
            wr(didx[p] + 10'h2, d);
            wr(didx[p], l);
            settle();
            rd(didx[p], rv, resp);
            check("port read", rv, {24'h0, exp_rd(d, l, e)});
            check("port oe", pin_oe[p*8 +: 8], d);
            check("port level", pin_out[p*8 +: 8] & d, l & d);
        end
        wr(didx[0] + 10'h2, 8'h03);
        wr(didx[1] + 10'h2, 8'h00);
        wr(`PIOPB_IDX_PULLUP0, 8'h05);
        settle();
        check("pullup port0", pin_pu[7:0], 8'h0C);
        check("pullup port1", pin_pu[15:8], 8'h0F);
        rd(didx[1], rv, resp);
        check("pulled read", rv, {24'h0, ext_lvl[15:12], 4'hF});
        wr(`PIOPB_IDX_PULLUP0, 8'h00);
        l = ~ext_lvl[15:8];
        wr(didx[1], l);
        wr(`PIOPB_IDX_READBACK, 8'h01);
        rd(didx[1], rv, resp);
        check("latch readback", rv, {24'h0, l});
        wr(`PIOPB_IDX_READBACK, 8'h00);
        wr(didx[8] + 10'h2, 8'hFF);
        wr(didx[8], 8'hFF);
        wr(didx[7] + 10'h2, 8'h02);
        for (int v = 0; v < 2; v++) begin
            ext_lvl[69] <= v[0];
            wr(didx[7], {6'h0, ~v[0], 1'b0});
            settle();
            rd(didx[8], rv, resp);
            check("shared input", rv[5], v[0]);
            check("shared undriven", pin_oe[69], 1'b0);
            check("open drain oe", pin_oe[57], v[0]);
        end
        wr(didx[11], 8'h5A);
        rd(didx[11], rv, resp);
        check("upper disabled", rv, 32'h0);
        wr(`PIOPB_IDX_PULLUP3, 8'h80);
        wr(didx[11] + 10'h2, 8'hFF);
        wr(didx[11], 8'h5A);
        rd(didx[11], rv, resp);
        check("upper enabled", rv, 32'h5A);
        wr(`PIOPB_IDX_PORT14_CTRL, 8'hFF);
        rd(`PIOPB_IDX_PORT14_CTRL, rv, resp);
        check("port14 fields", rv, 32'h33);
        settle();
        check("port14 drive", pin_oe[113:112], 2'h3);
        wr(`PIOPB_IDX_PULLUP3, 8'h00);
        wr(`PIOPB_IDX_PULLUP3, 8'h80);
        rd(didx[11], rv, resp);
        check("upper cleared", rv, 32'h0);
        // Direction left input while peripheral owns it
        periph_oe[8] <= 1'b1;
        periph_out[8] <= !l[0];
        settle();
        check("periph oe", pin_oe[8], 1'b1);
        check("periph level", pin_out[8], !l[0]);
        periph_oe[8] <= 1'b0;
        rd(10'h000, rv, resp);
        check("unmapped resp", resp, `PIOPB_RESP_DECERR);
        check("unmapped data", rv, 32'h0);
        print_verdict();
    end
endmodule

bind piopb_top piopb_props chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .periph_oe, .periph_out, .pin_out,
    .pin_oe, .pin_pu);
